// ### include/csio_pkg.sv
// ==========================================================================
// clocked serial channel constants
// ==========================================================================
package csio_pkg;
  // ========================================================================
  // register byte offsets
  // ========================================================================
  localparam logic [3:0] CSIO_OFS_MODE   = 4'h0;
  localparam logic [3:0] CSIO_OFS_CLKSEL = 4'h4;
  localparam logic [3:0] CSIO_OFS_DATA   = 4'h8;
  localparam logic [3:0] CSIO_OFS_STATUS = 4'hc;

  // ========================================================================
  // field positions
  // ========================================================================
  localparam int CSIO_MODE_EN_BIT    = 7;
  localparam int CSIO_MODE_TRMD_BIT  = 6;
  localparam int CSIO_MODE_SLAVE_BIT = 5;
  localparam int CSIO_MODE_DIR_BIT   = 4;
  localparam int CSIO_MODE_SSIE_BIT  = 0;
  localparam int CSIO_CLK_CKP_BIT    = 4;
  localparam int CSIO_CLK_DAP_BIT    = 3;
  localparam int CSIO_CLK_SEL_LSB    = 0;
  localparam int CSIO_STAT_BUSY_BIT  = 0;
  localparam int CSIO_STAT_OSC_BIT   = 1;

  // ========================================================================
  // reset values and counts
  // ========================================================================
  localparam logic [7:0] CSIO_MODE_RST   = 8'h00;
  localparam logic [7:0] CSIO_CLKSEL_RST = 8'h00; // ckp 0, dap 0: phase type 1
  localparam logic [2:0] CSIO_SEL_EXT    = 3'h7;  // serial clock from the pin
  localparam int         CSIO_FRAME_BITS = 8;
  localparam int         CSIO_DIV_W      = 9;     // holds the largest half period
  localparam int         CSIO_CLK_PERIOD_NS = 50;

  // ========================================================================
  // bus answers and pin carrier
  // ========================================================================
  localparam logic [1:0] CSIO_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CSIO_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic so_o;
    logic so_oe;
    logic port_release;
  } csio_pin_out_t;
endpackage

// ### src/csio_sync2.sv
`timescale 1ns/1ps
// ==========================================================================
// two-flop synchroniser for pin inputs
// ==========================================================================
module csio_sync2 #(
  parameter int W = 1
) (
  input  wire logic         CORE_CLK,
  input  wire logic         NRST,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ### src/csio_top.sv
`timescale 1ns/1ps
module csio_top #(
  parameter int DIV_W = csio_pkg::CSIO_DIV_W
) (
  input  wire logic                   CORE_CLK,
  input  wire logic                   NRST,
  input  wire logic                   S_AXI_AWVALID,
  output logic                        S_AXI_AWREADY,
  input  wire logic [3:0]             S_AXI_AWADDR,
  input  wire logic                   S_AXI_WVALID,
  output logic                        S_AXI_WREADY,
  input  wire logic [31:0]            S_AXI_WDATA,
  input  wire logic [3:0]             S_AXI_WSTRB,
  output logic                        S_AXI_BVALID,
  input  wire logic                   S_AXI_BREADY,
  output logic [1:0]                  S_AXI_BRESP,
  input  wire logic                   S_AXI_ARVALID,
  output logic                        S_AXI_ARREADY,
  input  wire logic [3:0]             S_AXI_ARADDR,
  output logic                        S_AXI_RVALID,
  input  wire logic                   S_AXI_RREADY,
  output logic [31:0]                 S_AXI_RDATA,
  output logic [1:0]                  S_AXI_RRESP,
  input  wire logic                   INT_OSC_SEL,
  input  wire logic                   SERIAL_CLOCK_PIN_I,
  input  wire logic                   SERIAL_DATA_IN_PIN,
  input  wire logic                   SLAVE_SELECT_INPUT_N,
  output csio_pkg::csio_pin_out_t     PINS
);
  import csio_pkg::*;

  // ========================================================================
  // elaboration check
  // ========================================================================
  if (DIV_W < CSIO_DIV_W) begin : g_bad_div
    $error("divider too narrow for the slowest clock select");
  end

  // ========================================================================
  // state
  // ========================================================================
  typedef struct packed {
    logic             en;
    logic             trmd;
    logic             slave;
    logic             dir;
    logic             ssie;
    logic [2:0]       sel;
    logic             ckp;
    logic             dap;
    logic [7:0]       sh;
    logic             so;
    logic             sck;
    logic             sck_prev;
    logic             busy;
    logic [4:0]       half;
    logic [DIV_W-1:0] div;
    logic             osc_warn;
    logic             awg;
    logic             wg;
    logic [3:0]       awaddr;
    logic [7:0]       wdata;
    logic             wlane;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [7:0]       rdata;
  } csio_state_t;

  csio_state_t st_reg;
  csio_state_t st_next;
  logic [2:0]  pin_q;
  logic        ssi_q;
  logic        si_q;
  logic        sck_q;

  // pins come from the partner's domain; master receive needs sel 1 or more
  csio_sync2 #(.W(3)) u_sync (
    .CORE_CLK (CORE_CLK),
    .NRST     (NRST),
    .d        ({SLAVE_SELECT_INPUT_N, SERIAL_DATA_IN_PIN, SERIAL_CLOCK_PIN_I}),
    .q        (pin_q)
  );
  assign ssi_q = pin_q[2];
  assign si_q  = pin_q[1];
  assign sck_q = pin_q[0];

  // ========================================================================
  // bus handshake outputs
  // ========================================================================
  assign S_AXI_AWREADY = !st_reg.awg && !st_reg.bvalid;
  assign S_AXI_WREADY  = !st_reg.wg && !st_reg.bvalid;
  assign S_AXI_BVALID  = st_reg.bvalid;
  assign S_AXI_BRESP   = st_reg.bresp;
  assign S_AXI_ARREADY = !st_reg.rvalid;
  assign S_AXI_RVALID  = st_reg.rvalid;
  assign S_AXI_RRESP   = st_reg.rresp;
  assign S_AXI_RDATA   = {24'h000000, st_reg.rdata};

  // ========================================================================
  // pins
  // ========================================================================
  logic release_w;
  logic ssi_ok;
  assign release_w = !st_reg.en && !st_reg.ckp;
  // slave select is active low; the partner sets it up ahead of clocking
  assign ssi_ok = !st_reg.ssie || !ssi_q;
  assign PINS = '{sck_o:        st_reg.sck,
                  sck_oe:       !release_w && !st_reg.slave,
                  so_o:         st_reg.so,
                  so_oe:        !release_w && st_reg.trmd && (!st_reg.slave || ssi_ok),
                  port_release: release_w};

  // ========================================================================
  // next state
  // ========================================================================
  logic             wr_do;
  logic             edge_w;
  logic             lead_w;
  logic             lvl_w;
  logic [DIV_W-1:0] div_lim;

  always_comb begin
    st_next = st_reg;
    edge_w  = 1'b0;
    lvl_w   = 1'b0;
    div_lim = DIV_W'((2 << st_reg.sel) - 1);
    st_next.sck_prev = sck_q;
    // internal oscillator still drives the divider, but the result is flagged
    st_next.osc_warn = INT_OSC_SEL && st_reg.en;

    // serial clock edges: own divider as master, synchronised pin as slave
    if (st_reg.busy && !st_reg.slave) begin
      if (st_reg.div == div_lim) begin
        st_next.div = '0;
        st_next.sck = !st_reg.sck;
        edge_w      = 1'b1;
        lvl_w       = !st_reg.sck;
      end else begin
        st_next.div = st_reg.div + 1'b1;
      end
    end else if (st_reg.busy && ssi_ok && (sck_q != st_reg.sck_prev)) begin
      edge_w = 1'b1;
      lvl_w  = sck_q;
    end
    // lead edge leaves the idle level, which is the inverse of ckp
    lead_w = edge_w && (lvl_w == st_reg.ckp);

    // data phase picks whether lead edge drives or samples
    if (edge_w) begin
      if (lead_w == st_reg.dap) begin
        st_next.so = st_reg.trmd && (st_reg.dir ? st_reg.sh[0] : st_reg.sh[7]);
      end else begin
        st_next.sh = st_reg.dir ? {si_q, st_reg.sh[7:1]} : {st_reg.sh[6:0], si_q};
      end
      st_next.half = st_reg.half + 1'b1;
      if (st_reg.half == 5'(2 * CSIO_FRAME_BITS - 1)) begin
        st_next.busy = 1'b0;
      end
    end

    // write address and data may arrive in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      st_next.awg    = 1'b1;
      st_next.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      st_next.wg    = 1'b1;
      st_next.wdata = S_AXI_WDATA[7:0];
      st_next.wlane = S_AXI_WSTRB[0];
    end
    if (st_reg.bvalid && S_AXI_BREADY) begin
      st_next.bvalid = 1'b0;
    end

    wr_do = st_reg.awg && st_reg.wg && !st_reg.bvalid;
    if (wr_do) begin
      st_next.awg    = 1'b0;
      st_next.wg     = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = CSIO_RESP_OKAY;
      if (st_reg.busy) begin
        // transfer in flight: access refused, nothing changes
        st_next.bresp = CSIO_RESP_SLVERR;
      end else if (st_reg.wlane) begin
        case (st_reg.awaddr)
          CSIO_OFS_MODE: begin
            st_next.en    = st_reg.wdata[CSIO_MODE_EN_BIT];
            st_next.trmd  = st_reg.wdata[CSIO_MODE_TRMD_BIT];
            st_next.slave = st_reg.wdata[CSIO_MODE_SLAVE_BIT];
            st_next.dir   = st_reg.wdata[CSIO_MODE_DIR_BIT];
            st_next.ssie  = st_reg.wdata[CSIO_MODE_SSIE_BIT];
            // data-out follows the new mode right away
            st_next.so = st_reg.wdata[CSIO_MODE_TRMD_BIT] &&
                         (st_reg.wdata[CSIO_MODE_DIR_BIT] ? st_reg.sh[0] : st_reg.sh[7]);
          end
          CSIO_OFS_CLKSEL: begin
            if (st_reg.en) begin
              // changing the clock under a live channel would glitch it
              st_next.bresp = CSIO_RESP_SLVERR;
            end else begin
              st_next.sel = st_reg.wdata[CSIO_CLK_SEL_LSB +: 3];
              st_next.ckp = st_reg.wdata[CSIO_CLK_CKP_BIT];
              st_next.dap = st_reg.wdata[CSIO_CLK_DAP_BIT];
              st_next.so  = st_reg.trmd && (st_reg.dir ? st_reg.sh[0] : st_reg.sh[7]);
            end
          end
          CSIO_OFS_DATA: begin
            st_next.sh = st_reg.wdata;
            st_next.so = st_reg.trmd && (st_reg.dir ? st_reg.wdata[0] : st_reg.wdata[7]);
            if (st_reg.en && (st_reg.slave || st_reg.sel != CSIO_SEL_EXT)) begin
              st_next.busy = 1'b1;
              st_next.half = '0;
              st_next.div  = '0;
            end
          end
          CSIO_OFS_STATUS: st_next.bresp = CSIO_RESP_OKAY;
          default:         st_next.bresp = CSIO_RESP_SLVERR;
        endcase
      end
    end

    // idle clock level tracks the phase bit
    if (!st_next.busy) begin
      st_next.sck = !st_next.ckp;
    end

    // reads answer one cycle after the address is taken
    if (st_reg.rvalid && S_AXI_RREADY) begin
      st_next.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = CSIO_RESP_OKAY;
      st_next.rdata  = 8'h00;
      case (S_AXI_ARADDR)
        CSIO_OFS_MODE: begin
          st_next.rdata[CSIO_MODE_EN_BIT]    = st_reg.en;
          st_next.rdata[CSIO_MODE_TRMD_BIT]  = st_reg.trmd;
          st_next.rdata[CSIO_MODE_SLAVE_BIT] = st_reg.slave;
          st_next.rdata[CSIO_MODE_DIR_BIT]   = st_reg.dir;
          st_next.rdata[CSIO_MODE_SSIE_BIT]  = st_reg.ssie;
        end
        CSIO_OFS_CLKSEL: begin
          st_next.rdata[CSIO_CLK_SEL_LSB +: 3] = st_reg.sel;
          st_next.rdata[CSIO_CLK_CKP_BIT]      = st_reg.ckp;
          st_next.rdata[CSIO_CLK_DAP_BIT]      = st_reg.dap;
        end
        CSIO_OFS_DATA:   st_next.rdata = st_reg.sh;
        CSIO_OFS_STATUS: begin
          st_next.rdata[CSIO_STAT_BUSY_BIT] = st_reg.busy;
          st_next.rdata[CSIO_STAT_OSC_BIT]  = st_reg.osc_warn;
        end
        default:         st_next.rresp = CSIO_RESP_SLVERR;
      endcase
      // mode and data are off limits mid-frame; status stays readable
      if (st_reg.busy && (S_AXI_ARADDR == CSIO_OFS_MODE || S_AXI_ARADDR == CSIO_OFS_DATA)) begin
        st_next.rresp = CSIO_RESP_SLVERR;
        st_next.rdata = 8'h00;
      end
    end
  end

  // ========================================================================
  // state register
  // ========================================================================
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      st_reg      <= '0;
      st_reg.en   <= CSIO_MODE_RST[CSIO_MODE_EN_BIT];
      st_reg.ckp  <= CSIO_CLKSEL_RST[CSIO_CLK_CKP_BIT];
      st_reg.dap  <= CSIO_CLKSEL_RST[CSIO_CLK_DAP_BIT];
      st_reg.sck  <= !CSIO_CLKSEL_RST[CSIO_CLK_CKP_BIT];
    end else begin
      st_reg <= st_next;
    end
  end

  // ========================================================================
  // assertions
  // ========================================================================
  reset_phase_a: assert property (@(posedge CORE_CLK)
    !NRST |=> (!st_reg.ckp && !st_reg.dap && st_reg.sck))
    else $error("phase not type one after reset");

  clksel_lock_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (wr_do && st_reg.en && st_reg.awaddr == CSIO_OFS_CLKSEL) |=>
      ($stable(st_reg.sel) && $stable(st_reg.ckp) && S_AXI_BRESP == CSIO_RESP_SLVERR))
    else $error("clock select changed while enabled");

  port_release_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    PINS.port_release |-> (!st_reg.ckp && !PINS.sck_oe && !PINS.so_oe))
    else $error("pins released with phase bit set");

  busy_refuse_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (wr_do && st_reg.busy) |=> ($stable({st_reg.en, st_reg.sel, st_reg.ckp, st_reg.dap}) &&
     S_AXI_BRESP == CSIO_RESP_SLVERR))
    else $error("write accepted during transfer");

  so_follow_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (wr_do && !st_reg.busy && st_reg.wlane && st_reg.awaddr == CSIO_OFS_MODE &&
     !st_reg.wdata[CSIO_MODE_TRMD_BIT]) |=> !PINS.so_o)
    else $error("data-out ignored mode write");

  osc_flag_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (INT_OSC_SEL && st_reg.en) |=> st_reg.osc_warn)
    else $error("oscillator warning not raised");

  frame_start_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    $rose(st_reg.busy) |-> (st_reg.half == 5'h00) ##1 st_reg.busy[*2])
    else $error("active flag dropped at frame start");

  frame_end_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    $fell(st_reg.busy) |-> ($past(st_reg.half) == 5'h0f && st_reg.half == 5'h10))
    else $error("active flag cleared before last bit");
endmodule

// ### sim/csio_partner.sv
`timescale 1ns/1ps
// ==========================================================
// serial partner: slave to our master, master to our slave
// ==========================================================
module csio_partner (
  input  wire logic       master_role,
  input  wire logic       sck_pin,
  input  wire logic       so_pin,
  input  wire logic       ckp,
  input  wire logic       dap,
  output logic            si,
  output logic            ext_sck,
  output logic            ss_n,
  output logic [7:0]      rx_byte,
  output int              n_edges
);
  logic       sck;
  logic [7:0] txs;
  int         k;

  // the clock we follow depends on who leads the frame
  assign sck = master_role ? ext_sck : sck_pin;

  // idle: clock at its rest level, select high
  initial begin
    ext_sck = 1'b1;
    ss_n = 1'b1;
    rx_byte = 8'h00;
    txs = 8'h00;
    k = 8;
    si = 1'b0;
    n_edges = 0;
  end

  // arm a byte; with dap 0 the first bit must sit on the line early
  task automatic load(input logic [7:0] b);
    txs = b;
    k = dap ? 0 : 1;
    si = dap ? ~si : b[7];
    n_edges = 0;
    rx_byte = 8'h00;
  endtask

  // lead edge leaves the rest level; sample lead for dap 0, trail for dap 1
  always @(sck) begin
    n_edges++;
    if ((sck === ckp) != dap) begin
      rx_byte = {rx_byte[6:0], so_pin};
    end else begin
      si = (k < 8) ? txs[7-k] : ~si; // held bit expires after the frame
      k++;
    end
  end

  // select settles one serial period before clocking starts
  task automatic master_frame(input int half_ns);
    ext_sck = !ckp;
    ss_n = 1'b0;
    #(2 * half_ns);
    repeat (16) begin
      ext_sck = !ext_sck;
      #(half_ns);
    end
    ss_n = 1'b1;
  endtask
endmodule

// ### sim/csio_top_bench.sv
`timescale 1ns/1ps
// ==========================================================
// bench signals
// ==========================================================
module csio_top_bench;
  import csio_pkg::*;
  logic          core_clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic          awready, wready, bvalid, arready, rvalid, int_osc, role;
  logic [3:0]    awaddr, araddr, wstrb;
  logic [31:0]   wdata, rdata;
  logic [1:0]    bresp, rresp;
  logic          si, ext_sck, ss_n, pckp, pdap;
  logic [7:0]    prx;
  int            pedges;
  csio_pin_out_t pins;
  int            n_mismatch = 0;
  int            n_tests = 0;

  csio_top dut (
    .CORE_CLK(core_clk), .NRST(nrst),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .INT_OSC_SEL(int_osc),
    .SERIAL_CLOCK_PIN_I(ext_sck), .SERIAL_DATA_IN_PIN(si),
    .SLAVE_SELECT_INPUT_N(ss_n), .PINS(pins)
  );

  csio_partner partner (
    .master_role(role), .sck_pin(pins.sck_o), .so_pin(pins.so_o),
    .ckp(pckp), .dap(pdap), .si(si), .ext_sck(ext_sck), .ss_n(ss_n),
    .rx_byte(prx), .n_edges(pedges)
  );

  // 50 ns core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ==========================================================
  // shared tasks
  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // a wait that ran dry ends the run
  task automatic hung(input int n);
    if (n >= 200) begin
      n_mismatch++;
      $display("MISMATCH at %0t: bus wait ran out", $time);
      give_verdict();
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er,
                    input string what);
    int   n;
    logic ah, wh;
    ah = 1'b0;
    wh = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 200 && !(ah && wh); n++) begin
      @(posedge core_clk);
      if (awvalid && awready) begin
        ah = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wh = 1'b1;
        wvalid <= 1'b0;
      end
    end
    hung(n);
    // raised only once address and data have both been taken
    bready <= 1'b1;
    for (n = 0; n < 200 && !bvalid; n++) @(posedge core_clk);
    hung(n);
    bready <= 1'b0;
    check(32'(bresp), 32'(er), what);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er,
                    input string what);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge core_clk);
      if (arready) break;
    end
    hung(n);
    arvalid <= 1'b0;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge core_clk);
      if (rvalid) break;
    end
    hung(n);
    rready <= 1'b0;
    check(rdata, ed, what);
    check(32'(rresp), 32'(er), what);
  endtask

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_reset();
    rd(CSIO_OFS_CLKSEL, 32'h0, CSIO_RESP_OKAY, "clksel at reset");
    check(32'(pins), 32'h11, "pins at reset");
    wr(CSIO_OFS_STATUS, 8'h03, CSIO_RESP_OKAY, "status write");
    rd(CSIO_OFS_STATUS, 32'h0, CSIO_RESP_OKAY, "status untouched");
    wstrb <= 4'he;
    wr(CSIO_OFS_MODE, 8'h80, CSIO_RESP_OKAY, "write without lane 0");
    wstrb <= 4'hf;
    rd(CSIO_OFS_MODE, 32'h0, CSIO_RESP_OKAY, "mode untouched");
    wr(CSIO_OFS_CLKSEL, 8'h18, CSIO_RESP_OKAY, "phase bits set");
    check(32'(pins.port_release), 32'h0, "pins kept with ckp 1");
    check(32'(pins.sck_o), 32'h0, "idle clock level");
    do_reset();
    rd(CSIO_OFS_CLKSEL, 32'h0, CSIO_RESP_OKAY, "clksel after rerun");
    $display("reset test done");
  endtask

  // master frame, refused accesses in mid-frame, then mode writes on data-out
  task automatic t_master();
    role = 1'b0;
    // sel 0 is too fast for the synchronised data-in round trip
    wr(CSIO_OFS_CLKSEL, 8'h01, CSIO_RESP_OKAY, "half period four");
    wr(CSIO_OFS_MODE, 8'hc0, CSIO_RESP_OKAY, "enable master");
    check(32'(pins.port_release), 32'h0, "pins taken when enabled");
    partner.load(8'h01);
    wr(CSIO_OFS_DATA, 8'ha5, CSIO_RESP_OKAY, "start frame");
    rd(CSIO_OFS_STATUS, 32'h1, CSIO_RESP_OKAY, "active mid-frame");
    rd(CSIO_OFS_DATA, 32'h0, CSIO_RESP_SLVERR, "data read mid-frame");
    wr(CSIO_OFS_DATA, 8'hff, CSIO_RESP_SLVERR, "data write mid-frame");
    repeat (60) @(posedge core_clk);
    rd(CSIO_OFS_STATUS, 32'h0, CSIO_RESP_OKAY, "frame over");
    check(32'(pedges), 32'd16, "clock edges in frame");
    check(32'(prx), 32'ha5, "byte at partner");
    rd(CSIO_OFS_DATA, 32'h01, CSIO_RESP_OKAY, "byte from partner");
    wr(CSIO_OFS_CLKSEL, 8'h03, CSIO_RESP_SLVERR, "clksel while enabled");
    rd(CSIO_OFS_CLKSEL, 32'h01, CSIO_RESP_OKAY, "clksel kept");
    wr(CSIO_OFS_MODE, 8'hd0, CSIO_RESP_OKAY, "lsb first");
    check(32'(pins.so_o), 32'h1, "data-out shows bit 0");
    wr(CSIO_OFS_MODE, 8'h90, CSIO_RESP_OKAY, "receive only");
    check(32'(pins.so_o), 32'h0, "data-out low");
    wr(CSIO_OFS_MODE, 8'hd0, CSIO_RESP_OKAY, "transmit again");
    check(32'(pins.so_o), 32'h1, "data-out back");
    int_osc <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(CSIO_OFS_STATUS, 32'h2, CSIO_RESP_OKAY, "oscillator warning");
    wr(CSIO_OFS_MODE, 8'h00, CSIO_RESP_OKAY, "disable");
    rd(CSIO_OFS_STATUS, 32'h0, CSIO_RESP_OKAY, "no warning when off");
    int_osc <= 1'b0;
    // second frame with clock phase and data phase both set
    pckp = 1'b1;
    pdap = 1'b1;
    wr(CSIO_OFS_CLKSEL, 8'h19, CSIO_RESP_OKAY, "phase bits set, sel 1");
    check(32'(pins.sck_o), 32'h0, "idle clock low with ckp 1");
    wr(CSIO_OFS_MODE, 8'hc0, CSIO_RESP_OKAY, "enable again");
    partner.load(8'h6e);
    wr(CSIO_OFS_DATA, 8'h3c, CSIO_RESP_OKAY, "start frame, dap 1");
    repeat (70) @(posedge core_clk);
    check(32'(pedges), 32'd16, "clock edges, dap 1");
    check(32'(prx), 32'h3c, "byte at partner, dap 1");
    rd(CSIO_OFS_DATA, 32'h6e, CSIO_RESP_OKAY, "byte from partner, dap 1");
    wr(CSIO_OFS_MODE, 8'h00, CSIO_RESP_OKAY, "disable again");
    pckp = 1'b0;
    pdap = 1'b0;
    $display("master test done");
  endtask

  // our side as slave, lsb first, select guarded
  task automatic t_slave();
    role = 1'b1;
    wr(CSIO_OFS_CLKSEL, 8'h07, CSIO_RESP_OKAY, "external clock");
    wr(CSIO_OFS_MODE, 8'hf1, CSIO_RESP_OKAY, "slave lsb first");
    partner.load(8'h35);
    wr(CSIO_OFS_DATA, 8'hc8, CSIO_RESP_OKAY, "arm slave");
    rd(CSIO_OFS_STATUS, 32'h1, CSIO_RESP_OKAY, "slave active");
    check(32'(pins.so_oe), 32'h0, "deselected data-out off");
    partner.master_frame(410);
    repeat (8) @(posedge core_clk);
    rd(CSIO_OFS_STATUS, 32'h0, CSIO_RESP_OKAY, "slave frame over");
    check(32'(prx), 32'h13, "lsb-first byte out");
    rd(CSIO_OFS_DATA, 32'hac, CSIO_RESP_OKAY, "lsb-first byte in");
    $display("slave test done");
  endtask

  // every input starts defined; the run ends in one place
  initial begin
    nrst = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    int_osc = 1'b0;
    role = 1'b0;
    wstrb = 4'hf;
    pckp = 1'b0;
    pdap = 1'b0;
    do_reset();
    t_reset();
    t_master();
    t_slave();
    give_verdict();
  end
endmodule
